// ---- kii_pkg.sv ----
// Package with register map, field layout and types of the key interrupt unit
package kii_pkg;

  localparam int unsigned KII_CHANNELS = 6;
  localparam int unsigned KII_ADDR_W = 22;
  localparam int unsigned KII_DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [19:0] KII_IDX_CTRL = 20'hFFF34;
  localparam logic [19:0] KII_IDX_FLAGS = 20'hFFF35;
  localparam logic [19:0] KII_IDX_ENABLE = 20'hFFF37;
  localparam logic [19:0] KII_IDX_STATUS = 20'hFFF38;
  localparam logic [19:0] KII_IDX_MASK = 20'hFFF39;

  // Control register field positions
  localparam int unsigned KII_CTRL_EDGE_BIT = 0;
  localparam int unsigned KII_CTRL_MODE_BIT = 7;

  // Status and mask bit positions
  localparam int unsigned KII_EVT_KEY_BIT = 0;
  localparam int unsigned KII_EVT_ACCESS_BIT = 1;
  localparam int unsigned KII_EVT_W = 2;

  // Reset values
  localparam logic [7:0] KII_CTRL_RST = 8'h00;
  localparam logic [5:0] KII_ENABLE_RST = 6'h00;
  localparam logic [5:0] KII_FLAGS_RST = 6'h00;
  localparam logic [1:0] KII_STATUS_RST = 2'h0;
  localparam logic [1:0] KII_MASK_RST = 2'h0;

  // Timing: bus answer comes this many cycles after the request is seen
  localparam int unsigned KII_BUS_LATENCY = 1;
  // Synchroniser depth on the key pins
  localparam int unsigned KII_SYNC_STAGES = 2;

  typedef enum logic
  {
    KII_BUS_IDLE = 1'b0,
    KII_BUS_ACK = 1'b1
  } kii_bus_state_t;

  typedef struct packed
  {
    logic rd;
    logic wr;
    logic [KII_ADDR_W-1:0] addr;
    logic [KII_DATA_W-1:0] wdata;
    logic [3:0] be;
  } kii_bus_req_t;

  typedef struct packed
  {
    logic flag_mode_sel;
    logic edge_polarity_sel;
  } kii_ctrl_t;

endpackage : kii_pkg

// ---- kii_sync.sv ----
// Two-stage synchroniser for the key input pins
`timescale 1ns/1ps
`default_nettype none

module kii_sync
#(
  parameter int unsigned WIDTH = 6
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  // First stage feeds only the second stage
  always_comb
  begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;

endmodule : kii_sync

`default_nettype wire

// ---- kii_top.sv ----
// Key input interrupt unit with Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none

module kii_top
#(
  parameter int unsigned CHANNELS = kii_pkg::KII_CHANNELS
)
(
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic [CHANNELS-1:0] KEY_INPUT_PINS,
  input wire logic [kii_pkg::KII_ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [kii_pkg::KII_DATA_W-1:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [kii_pkg::KII_DATA_W-1:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic KEY_IRQ,
  output logic IRQ
);

  // Lowest set bit as a one-hot vector
  function automatic logic [CHANNELS-1:0] lowest_one
  (
    input logic [CHANNELS-1:0] v
  );
    logic [CHANNELS-1:0] r;
    logic found;
    r = '0;
    found = 1'b0;
    for (int i = 0; i < CHANNELS; i++)
    begin
      if (v[i] && !found)
      begin
        r[i] = 1'b1;
        found = 1'b1;
      end
    end
    return r;
  endfunction : lowest_one

  // Register index of a byte address, or all ones if misaligned
  function automatic logic [19:0] reg_index
  (
    input logic [kii_pkg::KII_ADDR_W-1:0] a
  );
    if (a[1:0] != 2'h0)
    begin
      return 20'hFFFFF;
    end
    return a[kii_pkg::KII_ADDR_W-1:2];
  endfunction : reg_index

  kii_pkg::kii_bus_req_t req;
  logic [CHANNELS-1:0] pins_s;

  assign req.rd = AVS_READ;
  assign req.wr = AVS_WRITE;
  assign req.addr = AVS_ADDRESS;
  assign req.wdata = AVS_WRITEDATA;
  assign req.be = AVS_BYTEENABLE;

  kii_sync
  #(
    .WIDTH(CHANNELS)
  )
  u_sync
  (
    .clk(MCLK),
    .rst(SRST),
    .async_in(KEY_INPUT_PINS),
    .sync_out(pins_s)
  );

  // Bus slave state
  kii_pkg::kii_bus_state_t bus_r;
  kii_pkg::kii_bus_state_t bus_nxt;
  logic waitreq_r;
  logic waitreq_nxt;
  logic [kii_pkg::KII_DATA_W-1:0] rdata_r;
  logic [kii_pkg::KII_DATA_W-1:0] rdata_nxt;

  // Register state
  kii_pkg::kii_ctrl_t ctrl_r;
  kii_pkg::kii_ctrl_t ctrl_nxt;
  logic [CHANNELS-1:0] enable_r;
  logic [CHANNELS-1:0] enable_nxt;
  logic [CHANNELS-1:0] flags_r;
  logic [CHANNELS-1:0] flags_nxt;
  logic [kii_pkg::KII_EVT_W-1:0] status_r;
  logic [kii_pkg::KII_EVT_W-1:0] status_nxt;
  logic [kii_pkg::KII_EVT_W-1:0] mask_r;
  logic [kii_pkg::KII_EVT_W-1:0] mask_nxt;

  // Detection state
  logic [CHANNELS-1:0] prev_r;
  logic [CHANNELS-1:0] prev_nxt;
  logic [CHANNELS-1:0] en_prev_r;
  logic [CHANNELS-1:0] en_prev_nxt;
  logic [CHANNELS-1:0] pend_r;
  logic [CHANNELS-1:0] pend_nxt;
  logic req_prev_r;
  logic req_prev_nxt;
  logic key_irq_r;
  logic key_irq_nxt;
  logic irq_r;
  logic irq_nxt;

  logic [19:0] idx;
  logic commit;
  logic wr_commit;
  logic byte_wr;
  logic [7:0] wbyte;
  logic flag_access;

  logic [CHANNELS-1:0] active_lvl;
  logic [CHANNELS-1:0] active_edge;
  logic [CHANNELS-1:0] detect;
  logic [CHANNELS-1:0] load;
  logic key_req;
  logic access_evt;

  assign idx = reg_index(req.addr);
  // A request commits on the edge where waitrequest is seen low
  assign commit = (bus_r == kii_pkg::KII_BUS_ACK) && (req.rd || req.wr);
  assign wr_commit = commit && req.wr;
  // bit writes arrive as byte writes on lane 0
  assign byte_wr = wr_commit && req.be[0];
  assign wbyte = req.wdata[7:0];
  assign flag_access = commit && (idx == kii_pkg::KII_IDX_FLAGS);

  // Detection logic
  always_comb
  begin
    if (ctrl_r.edge_polarity_sel)
    begin
      active_lvl = pins_s;
      active_edge = pins_s & ~prev_r;
    end
    else
    begin
      active_lvl = ~pins_s;
      active_edge = ~pins_s & prev_r;
    end
    // arming a pin already active counts
    detect = enable_r & (active_edge | (active_lvl & ~en_prev_r));
    // queued edges wait until flags are empty
    if (ctrl_r.flag_mode_sel && (flags_r == '0))
    begin
      load = lowest_one(pend_r);
    end
    else
    begin
      load = '0;
    end
    // flag mode uses flags, level mode uses pin level
    // level request stays while any armed pin is active
    // all channels merge into one request
    if (ctrl_r.flag_mode_sel)
    begin
      key_req = |flags_r;
    end
    else
    begin
      key_req = |(enable_r & active_lvl);
    end
    // flag register touched in level mode
    access_evt = flag_access && !ctrl_r.flag_mode_sel;
  end

  // Detection next state
  always_comb
  begin
    prev_nxt = pins_s;
    en_prev_nxt = enable_r;
    // Set wins over the load that consumes a pending bit
    if (ctrl_r.flag_mode_sel)
    begin
      pend_nxt = (pend_r & ~load) | detect;
    end
    else
    begin
      pend_nxt = '0;
    end
    req_prev_nxt = key_req;
    key_irq_nxt = key_req && !req_prev_r;
  end

  // Register next state
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    enable_nxt = enable_r;
    flags_nxt = flags_r;
    mask_nxt = mask_r;
    status_nxt = status_r;
    if (byte_wr)
    begin
      case (idx)
        kii_pkg::KII_IDX_CTRL:
        begin
          // only mode and edge bits are kept
          ctrl_nxt.flag_mode_sel = wbyte[kii_pkg::KII_CTRL_MODE_BIT];
          ctrl_nxt.edge_polarity_sel = wbyte[kii_pkg::KII_CTRL_EDGE_BIT];
        end
        kii_pkg::KII_IDX_ENABLE:
        begin
          enable_nxt = wbyte[CHANNELS-1:0];
        end
        kii_pkg::KII_IDX_FLAGS:
        begin
          // zero clears, one leaves the bit alone
          if (ctrl_r.flag_mode_sel)
          begin
            flags_nxt = flags_r & wbyte[CHANNELS-1:0];
          end
        end
        kii_pkg::KII_IDX_MASK:
        begin
          mask_nxt = wbyte[kii_pkg::KII_EVT_W-1:0];
        end
        kii_pkg::KII_IDX_STATUS:
        begin
          status_nxt = status_r & ~wbyte[kii_pkg::KII_EVT_W-1:0];
        end
        default:
        begin
          ctrl_nxt = ctrl_r;
        end
      endcase
    end
    // flag set from the pending queue; never meets a clear
    // one flag, hence one request, per pending bit
    flags_nxt = flags_nxt | load;
    // Hardware set wins over the write-one clear
    status_nxt[kii_pkg::KII_EVT_KEY_BIT] =
      status_nxt[kii_pkg::KII_EVT_KEY_BIT] | key_irq_nxt;
    status_nxt[kii_pkg::KII_EVT_ACCESS_BIT] =
      status_nxt[kii_pkg::KII_EVT_ACCESS_BIT] | access_evt;
    irq_nxt = |(status_r & mask_r);
  end

  // Bus slave next state
  always_comb
  begin
    bus_nxt = bus_r;
    waitreq_nxt = 1'b1;
    rdata_nxt = rdata_r;
    case (bus_r)
      kii_pkg::KII_BUS_IDLE:
      begin
        if (req.rd || req.wr)
        begin
          bus_nxt = kii_pkg::KII_BUS_ACK;
          waitreq_nxt = 1'b0;
          rdata_nxt = '0;
          case (idx)
            kii_pkg::KII_IDX_CTRL:
            begin
              rdata_nxt[kii_pkg::KII_CTRL_MODE_BIT] = ctrl_r.flag_mode_sel;
              rdata_nxt[kii_pkg::KII_CTRL_EDGE_BIT] =
                ctrl_r.edge_polarity_sel;
            end
            kii_pkg::KII_IDX_ENABLE:
            begin
              rdata_nxt[CHANNELS-1:0] = enable_r;
            end
            kii_pkg::KII_IDX_FLAGS:
            begin
              // Flags read as zero in level mode
              if (ctrl_r.flag_mode_sel)
              begin
                rdata_nxt[CHANNELS-1:0] = flags_r;
              end
            end
            kii_pkg::KII_IDX_STATUS:
            begin
              rdata_nxt[kii_pkg::KII_EVT_W-1:0] = status_r;
            end
            kii_pkg::KII_IDX_MASK:
            begin
              rdata_nxt[kii_pkg::KII_EVT_W-1:0] = mask_r;
            end
            default:
            begin
              rdata_nxt = '0;
            end
          endcase
        end
      end
      kii_pkg::KII_BUS_ACK:
      begin
        bus_nxt = kii_pkg::KII_BUS_IDLE;
      end
      default:
      begin
        bus_nxt = kii_pkg::KII_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      bus_r <= kii_pkg::KII_BUS_IDLE;
      waitreq_r <= 1'b1;
      rdata_r <= '0;
    end
    else
    begin
      bus_r <= bus_nxt;
      waitreq_r <= waitreq_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      ctrl_r.flag_mode_sel <=
        kii_pkg::KII_CTRL_RST[kii_pkg::KII_CTRL_MODE_BIT];
      ctrl_r.edge_polarity_sel <=
        kii_pkg::KII_CTRL_RST[kii_pkg::KII_CTRL_EDGE_BIT];
      enable_r <= kii_pkg::KII_ENABLE_RST;
      flags_r <= kii_pkg::KII_FLAGS_RST;
      status_r <= kii_pkg::KII_STATUS_RST;
      mask_r <= kii_pkg::KII_MASK_RST;
      irq_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      enable_r <= enable_nxt;
      flags_r <= flags_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Prev samples reset to zero: a low pin after reset is not an edge
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      prev_r <= '0;
      en_prev_r <= '0;
      pend_r <= '0;
      req_prev_r <= 1'b0;
      key_irq_r <= 1'b0;
    end
    else
    begin
      prev_r <= prev_nxt;
      en_prev_r <= en_prev_nxt;
      pend_r <= pend_nxt;
      req_prev_r <= req_prev_nxt;
      key_irq_r <= key_irq_nxt;
    end
  end

  assign AVS_READDATA = rdata_r;
  assign AVS_WAITREQUEST = waitreq_r;
  assign KEY_IRQ = key_irq_r;
  assign IRQ = irq_r;

endmodule : kii_top

`default_nettype wire

// ---- kii_keys.sv ----
// Key switch model driving the six key pins
`timescale 1ns/1ps
`default_nettype none

module kii_keys
(
  input wire logic clk,
  input wire logic [5:0] want,
  input wire logic [1:0] lag,
  output logic [5:0] pins
);
  logic [5:0] hist_r [3];

  // Slow keys reach the pins up to three clocks late
  always_ff @(posedge clk)
  begin
    hist_r[0] <= want;
    for (int i = 1; i < 3; i++)
      hist_r[i] <= hist_r[i-1];
  end

  assign pins = (lag == 2'h0) ? want : hist_r[lag-2'h1];
endmodule : kii_keys
`default_nettype wire

// ---- kii_checker.sv ----
// Port assertions for the key interrupt unit
`timescale 1ns/1ps
`default_nettype none

module kii_checker
#(
  parameter int unsigned CHANNELS = 6
)
(
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic [CHANNELS-1:0] KEY_INPUT_PINS,
  input wire logic [21:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic KEY_IRQ,
  input wire logic IRQ
);
  logic [CHANNELS-1:0] pins_r;
  logic [3:0] quiet_r;
  logic [3:0] quiet_nxt;
  logic [2:0] cause_r;
  logic [2:0] cause_nxt;
  logic rd_ack;

  // Quiet time: no pin change and no bus answer, so no cause for a request
  always_comb
  begin
    quiet_nxt = quiet_r + {3'h0, quiet_r != 4'hF};
    if (KEY_INPUT_PINS != pins_r || !AVS_WAITREQUEST)
      quiet_nxt = 4'h0;
    cause_nxt = {cause_r[1:0], KEY_IRQ | !AVS_WAITREQUEST};
  end

  always_ff @(posedge MCLK)
  begin
    pins_r <= KEY_INPUT_PINS;
    quiet_r <= SRST ? 4'h0 : quiet_nxt;
    cause_r <= SRST ? 3'h0 : cause_nxt;
  end

  assign rd_ack = AVS_READ && !AVS_WAITREQUEST;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (SRST);

  sequence s_req;
    $rose(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  sequence s_ack;
    !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endsequence

  a_bus_one_wait: assert property (s_req |=> s_ack)
    else $error("bus answer not after one wait");
  a_ack_has_req: assert property (!AVS_WAITREQUEST |->
    $past(AVS_READ || AVS_WRITE)) else $error("answer without request");
  a_read_upper_zero: assert property (rd_ack |->
    AVS_READDATA[31:8] == 24'h0) else $error("upper read bits set");
  a_ctrl_zero: assert property (rd_ack && AVS_ADDRESS ==
    {kii_pkg::KII_IDX_CTRL, 2'h0} |-> AVS_READDATA[6:1] == 6'h00)
    else $error("control spare bits set");
  a_flags_zero: assert property (rd_ack && AVS_ADDRESS ==
    {kii_pkg::KII_IDX_FLAGS, 2'h0} |-> AVS_READDATA[7:6] == 2'h0)
    else $error("flag spare bits set");
  a_irq_single: assert property (KEY_IRQ |=> !KEY_IRQ)
    else $error("key request longer than one cycle");
  a_quiet_no_irq: assert property (quiet_r >= 4'h8 |-> !KEY_IRQ)
    else $error("key request without cause");
  a_irq_cause: assert property ($rose(IRQ) |-> cause_r != 3'h0)
    else $error("interrupt without event");
endmodule : kii_checker

bind kii_top kii_checker #(.CHANNELS(CHANNELS)) i_kii_checker
(
  .MCLK(MCLK), .SRST(SRST), .KEY_INPUT_PINS(KEY_INPUT_PINS),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .KEY_IRQ(KEY_IRQ), .IRQ(IRQ)
);
`default_nettype wire

// ---- kii_top_tb.sv ----
// Self-checking bench for the key interrupt unit
`timescale 1ns/1ps
`default_nettype none

module kii_top_tb;
  localparam logic [19:0] C = kii_pkg::KII_IDX_CTRL;
  localparam logic [19:0] F = kii_pkg::KII_IDX_FLAGS;
  localparam logic [19:0] E = kii_pkg::KII_IDX_ENABLE;
  localparam logic [19:0] S = kii_pkg::KII_IDX_STATUS;
  localparam logic [19:0] M = kii_pkg::KII_IDX_MASK;
  logic mclk, srst, rd, wr, waitreq, key_irq, irq;
  logic [5:0] keys, want;
  logic [1:0] lag;
  logic [21:0] addr;
  logic [31:0] wdata, rdata, q;
  logic [3:0] be;
  int n_fail, n_tests, n_irq, cyc;

  kii_top i_kii_top (.MCLK(mclk), .SRST(srst), .KEY_INPUT_PINS(keys),
    .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .KEY_IRQ(key_irq), .IRQ(irq));
  kii_keys i_kii_keys (.clk(mclk), .want(want), .lag(lag), .pins(keys));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  always @(negedge mclk)
    if (key_irq === 1'b1) n_irq++;

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_fail++;
      report_and_stop;
    end
  end

  task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // Request held until the edge that sees waitrequest low
  task bus(input logic w, input logic [19:0] idx, input logic [7:0] d);
    addr <= {idx, 2'h0};
    wdata <= {24'h0, d};
    rd <= !w;
    wr <= w;
    @(posedge mclk);
    while (waitreq !== 1'b0)
    begin
      @(posedge mclk);
    end
    // Read data stand in the answer cycle; take them at that edge
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge mclk);
  endtask : bus

  task rchk(input logic [19:0] idx, input logic [7:0] e, input string nm);
    bus(1'b0, idx, 8'h00);
    check(nm, q, {24'h0, e});
  endtask : rchk

  task seen(input int e);
    repeat (16) @(posedge mclk);
    check("key_irq", n_irq, e);
    n_irq = 0;
  endtask : seen

  task key(input logic [5:0] v, input int e);
    want <= v;
    seen(e);
  endtask : key

  task irqchk(input logic e);
    @(negedge mclk);
    check("irq", irq, e);
    @(posedge mclk);
  endtask : irqchk

  task report_and_stop;
    if (n_fail == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  initial
  begin
    srst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    addr = 22'h0;
    wdata = 32'h0;
    be = 4'hF;
    want = 6'h3F;
    lag = 2'h0;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    rchk(C, 8'h00, "ctrl");
    rchk(E, 8'h00, "enable");
    // Flag access in level mode is refused and noted in status
    rchk(F, 8'h00, "flags");
    rchk(S, 8'h02, "status");
    irqchk(1'b0);
    bus(1'b1, S, 8'h03);
    rchk(S, 8'h00, "status");
    // Arm before flag mode: idle pins sit at the rising level
    bus(1'b1, E, 8'hFF);
    rchk(E, 8'h3F, "enable");
    bus(1'b1, C, 8'hFF);
    rchk(C, 8'h81, "ctrl");
    be <= 4'h0;
    bus(1'b1, C, 8'h00);
    be <= 4'hF;
    rchk(C, 8'h81, "ctrl");
    bus(1'b1, C, 8'h00);
    bus(1'b1, E, 8'h00);
    // Arm while masked, drop any stale request, then unmask
    bus(1'b1, E, 8'h01);
    bus(1'b1, S, 8'h03);
    bus(1'b1, M, 8'h01);
    irqchk(1'b0);
    key(6'h3E, 1);
    irqchk(1'b1);
    // Pin 1 armed while pin 0 still holds the request
    bus(1'b1, E, 8'h03);
    seen(0);
    key(6'h3F, 0);
    key(6'h37, 0);
    key(6'h3B, 0);
    bus(1'b1, E, 8'h07);
    seen(1);
    key(6'h3F, 0);
    bus(1'b1, E, 8'h00);
    key(6'h00, 0);
    bus(1'b1, C, 8'h01);
    bus(1'b1, E, 8'h01);
    lag <= 2'h3;
    key(6'h01, 1);
    key(6'h00, 0);
    lag <= 2'h0;
    bus(1'b1, E, 8'h00);
    key(6'h3F, 0);
    bus(1'b1, S, 8'h03);
    bus(1'b1, C, 8'h80);
    bus(1'b1, E, 8'h3F);
    key(6'h3E, 1);
    rchk(F, 8'h01, "flags");
    key(6'h1C, 0);
    bus(1'b1, F, 8'hFF);
    rchk(F, 8'h01, "flags");
    bus(1'b1, F, 8'hFE);
    seen(1);
    rchk(F, 8'h02, "flags");
    key(6'h3F, 0);
    bus(1'b1, F, 8'hFD);
    seen(1);
    rchk(F, 8'h20, "flags");
    bus(1'b1, F, 8'hDF);
    seen(0);
    rchk(F, 8'h00, "flags");
    irqchk(1'b1);
    bus(1'b1, S, 8'h01);
    irqchk(1'b0);
    report_and_stop;
  end
endmodule : kii_top_tb
`default_nettype wire
